// [rtl/rsc_reset_source_controller.sv]
// reset source controller: cause collection, reset sequencing and cause register
//
// The implementer's own choice: strobed register access.
`timescale 1ns/100ps

//
// Contract
// - halt core, init registers, ports, disable irqs
// - data memory untouched, stack pointer reset
// - port latches 0xFF in open-drain mode
// - weak pull-ups on during and after reset
// - drive reset pin low on power resets
// - exit clears PC, selects internal oscillator
// - exit enables watchdog at clock divided 12
// - first fetch from address 0x0000
// - bit 6 read-only program memory error cause
module rsc_reset_source_controller #(
	parameter int unsigned HOLD_CNT = rsc_pkg::HOLD_CYCLES,
	parameter int unsigned WDT_DIVN = rsc_pkg::WDT_DIV
) (
	input  wire logic        clock,
	input  wire logic        rst_n,
	input  wire logic        supply_ok,
	input  wire logic        rst_pin_in,
	input  wire logic        comparator_out,
	input  wire logic        watchdog_timeout,
	input  wire logic        missing_clock_timeout,
	input  wire logic        prog_mem_error,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata_q,
	output logic             irq_q,
	output logic             cpu_halt_q,
	output logic             sfr_init_q,
	output logic             irq_timer_disable_q,
	output logic             sp_reset_q,
	output logic             ram_write_block_q,
	output logic      [7:0]  port_latch_q,
	output logic             port_open_drain_q,
	output logic             weak_pullup_en_q,
	output logic             rst_pin_out_q,
	output logic             rst_pin_oe_n_q,
	output logic             pc_clear_q,
	output logic             sysclk_internal_q,
	output logic             wdt_en_q,
	output logic             wdt_tick_q,
	output logic      [15:0] fetch_addr_q,
	output logic             fetch_start_q,
	output logic             supply_monitor_en_q,
	output logic             missing_clock_en_q,
	output logic             comparator_reset_en_q
);

	// ========================================================
	// declarations
	localparam int unsigned CW = $clog2(HOLD_CNT + 1);  // hold counter width
	localparam int unsigned DW = $clog2(WDT_DIVN + 1);  // divider width

	logic              supply_ok_s;     // synchronised supply good level
	logic              pin_n_s;         // synchronised reset pin, low = asserted
	logic              comp_s;          // synchronised comparator output
	rsc_pkg::rsc_state_e state_q;       // sequencer state
	rsc_pkg::rsc_state_e state_d;       // next sequencer state
	logic [CW-1:0]     hold_cnt_q;      // cycles spent in hold
	logic [DW-1:0]     wdt_div_q;       // watchdog prescaler
	logic [7:0]        cause_q;         // one-hot cause of last reset
	logic [7:0]        cause_d;         // cause chosen by priority
	logic [7:0]        status_q;        // sticky event bits
	logic [7:0]        mask_q;          // interrupt mask
	logic              power_rst_q;     // current hold stems from power or supply
	logic              trig_supply;     // supply monitor trip, gated by enable
	logic              trig_pin;        // external pin asserted
	logic              trig_mcd;        // missing clock trip, gated by enable
	logic              trig_comp;       // comparator trip, gated by enable
	logic              trig_sw;         // software force write
	logic              any_trig;        // any cause active this cycle
	logic              src_active;      // supply or pin cause still asserted
	logic              wr_cause;        // write hit on cause register
	logic              rd_status;       // read hit on status register
	logic [1:0]        oe_n_dly_q;      // pin enable as the synchroniser still shows it

	// ========================================================
	// synchronisers for pin and analog-side levels
	rsc_sync #(
		.WIDTH   (3),
		.RST_VAL (3'h7)
	) u_sync (
		.clock    (clock),
		.rst_n    (rst_n),
		.async_in ({supply_ok, rst_pin_in, comparator_out}),
		.sync_q   ({supply_ok_s, pin_n_s, comp_s})
	);

	// ========================================================
	// cause detection
	always_comb begin
		wr_cause  = reg_wr && (reg_addr == rsc_pkg::REG_CAUSE_OFS);
		rd_status = reg_rd && (reg_addr == rsc_pkg::REG_STATUS_OFS);
		// supply monitor counts only while selected as a source
		trig_supply = supply_monitor_en_q && !supply_ok_s;
		// our own low drive on the pin must not look like an outside reset
		// the synchronised pin lags our drive by two edges, so mask that long
		trig_pin  = !pin_n_s && rst_pin_oe_n_q && oe_n_dly_q[1];
		trig_mcd  = missing_clock_en_q && missing_clock_timeout;
		// comparator trips when its output is low
		trig_comp = comparator_reset_en_q && !comp_s;
		trig_sw   = wr_cause && reg_wdata[rsc_pkg::BIT_SW];
		any_trig  = trig_supply || trig_pin || trig_mcd || trig_comp
			|| watchdog_timeout || prog_mem_error || trig_sw;
		// hold is stretched while the supply or pin cause remains
		src_active = trig_supply || trig_pin;
	end

	// ========================================================
	// cause priority: supply, pin, clock, comparator, watchdog, memory, software
	always_comb begin
		cause_d = 8'h00;
		if (trig_supply) begin
			cause_d[rsc_pkg::BIT_POR] = 1'b1;
		end else if (trig_pin) begin
			cause_d[rsc_pkg::BIT_PIN] = 1'b1;
		end else if (trig_mcd) begin
			cause_d[rsc_pkg::BIT_MCD] = 1'b1;
		end else if (trig_comp) begin
			cause_d[rsc_pkg::BIT_COMP] = 1'b1;
		end else if (watchdog_timeout) begin
			cause_d[rsc_pkg::BIT_WDT] = 1'b1;
		end else if (prog_mem_error) begin
			cause_d[rsc_pkg::BIT_PROG_ERR] = 1'b1;
		end else if (trig_sw) begin
			cause_d[rsc_pkg::BIT_SW] = 1'b1;
		end
	end

	// ========================================================
	// sequencer next state
	always_comb begin
		state_d = state_q;
		case (state_q)
			rsc_pkg::ST_RUN: begin
				if (any_trig) begin
					state_d = rsc_pkg::ST_HOLD;
				end
			end
			rsc_pkg::ST_HOLD: begin
				// leave only after the least hold and once the source is gone
				if ((hold_cnt_q >= CW'(HOLD_CNT - 1)) && !src_active) begin
					state_d = rsc_pkg::ST_EXIT;
				end
			end
			rsc_pkg::ST_EXIT: begin
				state_d = rsc_pkg::ST_RUN;
			end
			default: begin
				state_d = rsc_pkg::ST_HOLD;
			end
		endcase
	end

	// ========================================================
	// sequencer state; power-on is the block's own reset
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			state_q <= rsc_pkg::ST_HOLD;
		end else begin
			state_q <= state_d;
		end
	end

	// ========================================================
	// hold counter restarts while the supply or pin cause is active inside the hold
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			hold_cnt_q <= '0;
		end else if (state_q != rsc_pkg::ST_HOLD) begin
			hold_cnt_q <= '0;
		end else if (src_active) begin
			hold_cnt_q <= '0;
		end else if (hold_cnt_q < CW'(HOLD_CNT)) begin
			hold_cnt_q <= hold_cnt_q + CW'(1);
		end
	end

	// ========================================================
	// kind of the current hold, steers the reset pin drive
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			power_rst_q <= 1'b1;
		end else if (state_q == rsc_pkg::ST_RUN && any_trig) begin
			power_rst_q <= trig_supply;
		end else if (state_q == rsc_pkg::ST_EXIT) begin
			power_rst_q <= 1'b0;
		end
	end

	// ========================================================
	// last reset cause; power resets leave the other flags cleared
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cause_q <= 8'h00;
			cause_q[rsc_pkg::BIT_POR] <= 1'b1;
		end else if (state_q == rsc_pkg::ST_RUN && any_trig) begin
			cause_q <= cause_d;
		end
	end

	// ========================================================
	// source enables, written by whole-byte stores only
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			supply_monitor_en_q   <= 1'b1;
			missing_clock_en_q    <= 1'b0;
			comparator_reset_en_q <= 1'b0;
		end else if (state_q == rsc_pkg::ST_HOLD) begin
			// other enables return to off; the supply source survives
			missing_clock_en_q    <= 1'b0;
			comparator_reset_en_q <= 1'b0;
		end else if (wr_cause) begin
			// a write with this bit clear drops the supply source
			supply_monitor_en_q   <= reg_wdata[rsc_pkg::BIT_POR];
			missing_clock_en_q    <= reg_wdata[rsc_pkg::BIT_MCD];
			comparator_reset_en_q <= reg_wdata[rsc_pkg::BIT_COMP];
		end
	end

	// ========================================================
	// core side outputs during the reset state
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			cpu_halt_q          <= 1'b1;
			sfr_init_q          <= 1'b1;
			irq_timer_disable_q <= 1'b1;
			sp_reset_q          <= 1'b1;
		end else begin
			cpu_halt_q          <= (state_d != rsc_pkg::ST_RUN);
			sfr_init_q          <= (state_d == rsc_pkg::ST_HOLD);
			irq_timer_disable_q <= (state_d != rsc_pkg::ST_RUN);
			sp_reset_q          <= (state_d == rsc_pkg::ST_HOLD);
		end
	end

	// ========================================================
	// data memory is only frozen, never cleared, so contents survive
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			ram_write_block_q <= 1'b1;
		end else begin
			ram_write_block_q <= (state_d != rsc_pkg::ST_RUN);
		end
	end

	// ========================================================
	// port pins: latches high, open drain, pull-ups always on
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			port_latch_q      <= rsc_pkg::PORT_LATCH_RST;
			port_open_drain_q <= 1'b1;
			weak_pullup_en_q  <= 1'b1;
		end else begin
			if (state_d == rsc_pkg::ST_HOLD) begin
				port_latch_q      <= rsc_pkg::PORT_LATCH_RST;
				port_open_drain_q <= 1'b1;
			end
			weak_pullup_en_q <= 1'b1;
		end
	end

	// ========================================================
	// reset pin: open drain, low only during power holds
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			rst_pin_out_q  <= 1'b0;
			rst_pin_oe_n_q <= 1'b0;
			oe_n_dly_q     <= 2'b00;
		end else begin
			rst_pin_out_q <= 1'b0;
			oe_n_dly_q    <= {oe_n_dly_q[0], rst_pin_oe_n_q};
			if (state_q == rsc_pkg::ST_RUN && trig_supply) begin
				rst_pin_oe_n_q <= 1'b0;
			end else if (state_q == rsc_pkg::ST_HOLD && power_rst_q) begin
				rst_pin_oe_n_q <= (state_d != rsc_pkg::ST_HOLD);
			end else begin
				rst_pin_oe_n_q <= 1'b1;
			end
		end
	end

	// ========================================================
	// exit actions: program counter, clock source, fetch start
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			pc_clear_q        <= 1'b0;
			sysclk_internal_q <= 1'b1;
			fetch_addr_q      <= rsc_pkg::FETCH_ADDR_RST;
			fetch_start_q     <= 1'b0;
		end else begin
			pc_clear_q    <= (state_q == rsc_pkg::ST_EXIT);
			fetch_start_q <= (state_q == rsc_pkg::ST_EXIT);
			if (state_q != rsc_pkg::ST_RUN) begin
				sysclk_internal_q <= 1'b1;
				fetch_addr_q      <= rsc_pkg::FETCH_ADDR_RST;
			end
		end
	end

	// ========================================================
	// watchdog enable and divide-by-twelve tick
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			wdt_en_q   <= 1'b0;
			wdt_div_q  <= '0;
			wdt_tick_q <= 1'b0;
		end else if (state_q != rsc_pkg::ST_RUN) begin
			// armed on exit so the tick starts with the first instruction
			wdt_en_q   <= (state_q == rsc_pkg::ST_EXIT);
			wdt_div_q  <= '0;
			wdt_tick_q <= 1'b0;
		end else if (wdt_en_q) begin
			if (wdt_div_q == DW'(WDT_DIVN - 1)) begin
				wdt_div_q  <= '0;
				wdt_tick_q <= 1'b1;
			end else begin
				wdt_div_q  <= wdt_div_q + DW'(1);
				wdt_tick_q <= 1'b0;
			end
		end else begin
			wdt_tick_q <= 1'b0;
		end
	end

	// ========================================================
	// sticky event status; a new event beats the read clear
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			status_q <= rsc_pkg::STATUS_RST;
		end else if (state_q == rsc_pkg::ST_RUN && any_trig) begin
			status_q <= cause_d | (rd_status ? 8'h00 : status_q);
		end else if (rd_status) begin
			status_q <= 8'h00;
		end
	end

	// ========================================================
	// interrupt mask register
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			mask_q <= rsc_pkg::MASK_RST;
		end else if (reg_wr && reg_addr == rsc_pkg::REG_MASK_OFS) begin
			mask_q <= reg_wdata;
		end
	end

	// ========================================================
	// level interrupt from unmasked status
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			irq_q <= 1'b0;
		end else begin
			irq_q <= |(status_q & mask_q);
		end
	end

	// ========================================================
	// read port, data one cycle after the strobe, zero otherwise
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			reg_rdata_q <= 8'h00;
		end else if (!reg_rd) begin
			reg_rdata_q <= 8'h00;
		end else if (reg_addr == rsc_pkg::REG_CAUSE_OFS) begin
			// enable bits read back as cause flags, not as written
			reg_rdata_q <= cause_q;
			reg_rdata_q[rsc_pkg::BIT_ONE] <= 1'b1;
		end else if (reg_addr == rsc_pkg::REG_STATUS_OFS) begin
			reg_rdata_q <= status_q;
		end else if (reg_addr == rsc_pkg::REG_MASK_OFS) begin
			reg_rdata_q <= mask_q;
		end else begin
			reg_rdata_q <= 8'h00;
		end
	end

	// supply monitor should be enabled early by firmware; nothing here waits on it

endmodule

// [rtl/rsc_pkg.sv]
// constants shared by the reset source controller design files
package rsc_pkg;

	// ========================================================
	// clock and timing
	localparam int unsigned CLK_PERIOD_NS  = 10;     // system clock period at 100 MHz
	localparam int unsigned RESET_HOLD_NS  = 100;    // least time the reset state is held
	localparam int unsigned HOLD_CYCLES    = (RESET_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int unsigned WDT_DIV        = 12;     // watchdog clock = system clock / 12

	// ========================================================
	// register offsets
	localparam logic [7:0] REG_CAUSE_OFS   = 8'hEF;  // reset_cause_and_enable
	localparam logic [7:0] REG_STATUS_OFS  = 8'hE8;  // sticky event status, read clears
	localparam logic [7:0] REG_MASK_OFS    = 8'hE9;  // interrupt mask

	// ========================================================
	// reset_cause_and_enable field positions
	localparam int unsigned BIT_ONE        = 7;      // unused, reads 1
	localparam int unsigned BIT_PROG_ERR   = 6;      // prog_mem_error_flag
	localparam int unsigned BIT_COMP       = 5;      // comparator_reset_enable_flag
	localparam int unsigned BIT_SW         = 4;      // software_reset_force_flag
	localparam int unsigned BIT_WDT        = 3;      // watchdog_reset_flag
	localparam int unsigned BIT_MCD        = 2;      // missing_clock_reset_flag
	localparam int unsigned BIT_POR        = 1;      // power_on_reset_enable_flag
	localparam int unsigned BIT_PIN        = 0;      // reset_pin_flag

	// ========================================================
	// reset values
	localparam logic [7:0]  PORT_LATCH_RST = 8'hFF;  // port latches after reset
	localparam logic [15:0] FETCH_ADDR_RST = 16'h0000; // first fetch address
	localparam logic [7:0]  MASK_RST       = 8'h00;  // all interrupts masked
	localparam logic [7:0]  STATUS_RST     = 8'h00;  // no events pending

	// ========================================================
	// sequencer states
	typedef enum logic [2:0] {
		ST_RUN  = 3'b001,  // processor running
		ST_HOLD = 3'b010,  // reset in force
		ST_EXIT = 3'b100   // one cycle of release actions
	} rsc_state_e;

endpackage

// [rtl/rsc_sync.sv]
// two flip-flop synchroniser for asynchronous levels
`timescale 1ns/100ps

module rsc_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  wire logic             clock,
	input  wire logic             rst_n,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_q
);

	// ========================================================
	// storage
	logic [WIDTH-1:0] meta_q;  // first stage, read by second stage only

	// ========================================================
	// two stages; the first is never looked at by other logic
	always_ff @(posedge clock) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end else begin
			meta_q <= async_in;
			sync_q <= meta_q;
		end
	end

endmodule

// [test/rsc_chk_asserts.sv]
// port-level checks for the reset source controller
`timescale 1ns/100ps

// ========================================
// checker
module rsc_chk_asserts #(
	parameter int unsigned HOLD_CNT = 10,
	parameter int unsigned WDT_DIVN = 12
) (
	input wire logic        clock,
	input wire logic        rst_n,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata_q,
	input wire logic        cpu_halt_q,
	input wire logic        sfr_init_q,
	input wire logic        irq_timer_disable_q,
	input wire logic        sp_reset_q,
	input wire logic        ram_write_block_q,
	input wire logic [7:0]  port_latch_q,
	input wire logic        port_open_drain_q,
	input wire logic        weak_pullup_en_q,
	input wire logic        rst_pin_out_q,
	input wire logic        rst_pin_oe_n_q,
	input wire logic        pc_clear_q,
	input wire logic        sysclk_internal_q,
	input wire logic        wdt_en_q,
	input wire logic        wdt_tick_q,
	input wire logic [15:0] fetch_addr_q,
	input wire logic        fetch_start_q
);
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	logic [7:0] gap_q;  // cycles since the last tick
	logic       seen_q; // a tick seen in this run
	// tick spacing; restarted by any halt, since the divider restarts too
	always_ff @(posedge clock) begin
		if (!rst_n || cpu_halt_q) begin
			gap_q  <= 8'h00;
			seen_q <= 1'b0;
		end else begin
			gap_q  <= wdt_tick_q ? 8'h00 : gap_q + 8'h01;
			seen_q <= seen_q | wdt_tick_q;
		end
	end
	sequence s_exit; $fell(cpu_halt_q); endsequence
	sequence s_rd_cause; reg_rd && reg_addr == 8'hEF; endsequence
	sequence s_sw_req; reg_wr && reg_addr == 8'hEF && reg_wdata[4] && !cpu_halt_q; endsequence
	property p_exit;
		s_exit |-> pc_clear_q && fetch_start_q && fetch_addr_q == 16'h0000 ##1 !pc_clear_q;
	endproperty
	property p_wdt_en; s_exit |-> wdt_en_q && sysclk_internal_q; endproperty
	property p_entry;
		$rose(cpu_halt_q) |-> sfr_init_q && sp_reset_q && irq_timer_disable_q && ram_write_block_q;
	endproperty
	property p_port; port_latch_q == 8'hFF && port_open_drain_q; endproperty
	property p_pullup; weak_pullup_en_q; endproperty
	property p_pin; !rst_pin_oe_n_q |-> !rst_pin_out_q && cpu_halt_q; endproperty
	property p_sw; s_sw_req |=> cpu_halt_q; endproperty
	property p_rd;
		s_rd_cause |=> reg_rdata_q[7] ##1 (reg_rdata_q == 8'h00 || $past(reg_rd));
	endproperty
	property p_tick;
		seen_q && !cpu_halt_q |-> gap_q < 8'(WDT_DIVN) && wdt_tick_q == (gap_q == 8'(WDT_DIVN - 1));
	endproperty
	a_exit: assert property (p_exit) else $error("exit pulse wrong");
	a_wdt_en: assert property (p_wdt_en) else $error("exit state wrong");
	a_entry: assert property (p_entry) else $error("reset entry wrong");
	a_port: assert property (p_port) else $error("port state wrong");
	a_pullup: assert property (p_pullup) else $error("pull-ups off");
	a_pin: assert property (p_pin) else $error("pin driven wrongly");
	a_sw: assert property (p_sw) else $error("forced reset missed");
	a_rd: assert property (p_rd) else $error("cause read wrong");
	a_tick: assert property (p_tick) else $error("tick spacing wrong");
endmodule

bind rsc_reset_source_controller rsc_chk_asserts #(.HOLD_CNT(HOLD_CNT), .WDT_DIVN(WDT_DIVN)) u_chk (
	.clock, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata_q, .cpu_halt_q,
	.sfr_init_q, .irq_timer_disable_q, .sp_reset_q, .ram_write_block_q, .port_latch_q,
	.port_open_drain_q, .weak_pullup_en_q, .rst_pin_out_q, .rst_pin_oe_n_q, .pc_clear_q,
	.sysclk_internal_q, .wdt_en_q, .wdt_tick_q, .fetch_addr_q, .fetch_start_q);

// [test/rsc_src_model.sv]
// model of the reset sources and the external reset pin
`timescale 1ns/100ps

// ========================================
// source model
module rsc_src_model (
	input  wire logic       clock,
	input  wire logic       go,
	input  wire logic [2:0] kind,
	input  wire logic       rst_pin_oe_n_q,
	output logic            supply_ok,
	output logic            rst_pin_in,
	output logic            comparator_out,
	output logic            watchdog_timeout,
	output logic            missing_clock_timeout,
	output logic            prog_mem_error
);
	logic [2:0] kind_q = 3'h0; // source being tripped
	logic [2:0] left_q = 3'h0; // cycles the trip still stands
	logic       act;           // a trip in force
	// levels stand four cycles so the synchronisers see them; events pulse once
	always_ff @(posedge clock) begin
		if (go) begin
			kind_q <= kind;
			left_q <= (kind < 3'h3) ? 3'h4 : 3'h1;
		end else if (left_q != 3'h0) begin
			left_q <= left_q - 3'h1;
		end
	end
	assign act                   = (left_q != 3'h0);
	// supply, pin and comparator trip low; the others trip high
	assign supply_ok             = !(act && kind_q == 3'h0);
	// the pin reads low whenever the controller drives it
	assign rst_pin_in            = !(act && kind_q == 3'h1) && rst_pin_oe_n_q;
	assign comparator_out        = !(act && kind_q == 3'h2);
	assign watchdog_timeout      = act && kind_q == 3'h3;
	assign missing_clock_timeout = act && kind_q == 3'h4;
	assign prog_mem_error        = act && kind_q == 3'h5;
endmodule

// [test/rsc_reset_source_controller_tb.sv]
// self-checking bench for the reset source controller
`timescale 1ns/100ps

// ========================================
// bench top
module rsc_reset_source_controller_tb;
	localparam int unsigned HOLD = 2; // short hold keeps the run brief
	logic        clock = 1'b0;
	logic        rst_n = 1'b0;
	logic [7:0]  reg_addr = 8'h00;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        go = 1'b0;    // trip request to the model
	logic [2:0]  kind = 3'h0;  // source to trip
	logic        supply_ok, rst_pin_in, comparator_out;
	logic        watchdog_timeout, missing_clock_timeout, prog_mem_error;
	logic [7:0]  reg_rdata_q, port_latch_q;
	logic [15:0] fetch_addr_q;
	logic        irq_q, cpu_halt_q, sfr_init_q, irq_timer_disable_q, sp_reset_q;
	logic        ram_write_block_q, port_open_drain_q, weak_pullup_en_q, rst_pin_out_q;
	logic        rst_pin_oe_n_q, pc_clear_q, sysclk_internal_q, wdt_en_q, wdt_tick_q;
	logic        fetch_start_q, supply_monitor_en_q, missing_clock_en_q, comparator_reset_en_q;
	int          tests_run = 0;
	int          miscompares = 0;
	logic [7:0]  rv;   // last read data
	logic        oe_v; // pin enable seen at halt

	rsc_reset_source_controller #(.HOLD_CNT(HOLD), .WDT_DIVN(12)) u_dut (.*);
	rsc_src_model u_src (.*);

	always #5 clock = ~clock;

	// ========================================
	// shared tasks
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
		@(posedge clock);
	endtask
	// read data stands only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 rv = reg_rdata_q;
		@(posedge clock);
	endtask
	// bounded wait for the halt level, sampled clear of the edge
	task automatic wait_for(input logic lvl);
		int n;
		n = 0;
		do begin
			@(posedge clock);
			#1 n++;
		end while (cpu_halt_q !== lvl && n < 60);
		oe_v = rst_pin_oe_n_q;
		chk(16'(cpu_halt_q), 16'(lvl));
		@(posedge clock);
	endtask
	task automatic trip(input logic [2:0] k);
		kind <= k;
		go <= 1'b1;
		@(posedge clock);
		go <= 1'b0;
	endtask

	// ========================================
	// scenarios
	task automatic t_power();
		repeat (8) @(posedge clock);
		#1 chk(16'({rst_pin_oe_n_q, rst_pin_out_q}), 16'h0000);
		chk(16'({port_latch_q, port_open_drain_q, weak_pullup_en_q}), 16'h03FF);
		chk(16'({cpu_halt_q, irq_timer_disable_q, ram_write_block_q, sp_reset_q, sfr_init_q}),
			16'h001F);
		@(posedge clock);
		rst_n <= 1'b1;
		wait_for(1'b0);
		chk(fetch_addr_q, 16'h0000);
		chk(16'({wdt_en_q, sysclk_internal_q}), 16'h0003);
		wr(8'hEF, 8'h02);
		rd(8'hEF);
		chk(16'(rv), 16'h0082);
		rd(8'h10);
		chk(16'(rv), 16'h0000);
	endtask
	// every source but software in turn, each enabled by a whole-byte write first
	task automatic t_sources();
		logic [7:0] en [6] = '{8'h02, 8'h02, 8'h22, 8'h02, 8'h06, 8'h02};
		logic [7:0] ex [6] = '{8'h82, 8'h81, 8'hA0, 8'h88, 8'h84, 8'hC0};
		for (int i = 0; i < 6; i++) begin
			wr(8'hEF, en[i]);
			trip(3'(i));
			wait_for(1'b1);
			chk(16'(oe_v), 16'(i != 0));
			wait_for(1'b0);
			chk(16'({missing_clock_en_q, comparator_reset_en_q}), 16'h0000);
			rd(8'hEF);
			chk(16'(rv), 16'(ex[i]));
		end
	endtask
	task automatic t_sw();
		wr(8'hEF, 8'h12);
		wait_for(1'b1);
		chk(16'(oe_v), 16'h0001);
		wait_for(1'b0);
		wr(8'hEF, 8'h42);
		rd(8'hEF);
		chk(16'(rv), 16'h0090);
		trip(3'h4);
		repeat (6) @(posedge clock);
		#1 chk(16'(cpu_halt_q), 16'h0000);
		@(posedge clock);
		wr(8'hEF, 8'h00);
		#1 chk(16'(supply_monitor_en_q), 16'h0000);
		@(posedge clock);
		wr(8'hEF, 8'h02);
	endtask
	task automatic t_irq();
		rd(8'hE8);
		wr(8'hEF, 8'h12);
		wait_for(1'b1);
		wait_for(1'b0);
		wr(8'hE9, 8'h00);
		#1 chk(16'(irq_q), 16'h0000);
		@(posedge clock);
		wr(8'hE9, 8'h10);
		#1 chk(16'(irq_q), 16'h0001);
		@(posedge clock);
		rd(8'hE8);
		#1 chk(16'({rv[6:0], irq_q}), 16'h0020);
		@(posedge clock);
	endtask

	// ========================================
	// verdict
	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#50000;
		miscompares++;
		test_done();
	end

	initial begin
		t_power();
		t_sources();
		t_sw();
		t_irq();
		test_done();
	end
endmodule
